// ==== core/cfd_top.sv ====
// Purpose: fault diagnostics for a multi-cell monitor behind an AXI4-Lite slave
// Assumes: scan results, oscillator and internal fault flags come from the device core
// Notes: sleep entered on oscillator fault is left only by wake_cmd
//
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
// Contract
// - internal fault inputs are watched every cycle and set fault status bits
// - oscillator fault sets its status flag first, sleep follows one cycle later; here sleep follows only if that flag was clear before
// - while asleep normal commands get no answer; downstream reports the failure
// - overvoltage limit is a 14-bit host-written register, 14'h1FFF is 5V
// - undervoltage limit is a separate 14-bit register on the same scale
// - filter sample count field resets to 3'b011, eight samples
// - cell setup bit 0 means connected, 1 means not connected
// - unconnected cells never raise an overvoltage fault
// - overvoltage flagged only after programmed count of consecutive hits
// - first fault while status is zero sends status report unprompted
// - any change of the filter sample count clears all filter counts
// - a non-hit result clears that cell's overvoltage count
// - fault output low while any fault status bit is set
module cfd_top #(
	parameter int CELLS = cfd_pkg::CELLS,
	parameter logic [13:0] FULL_SCALE = cfd_pkg::FULL_SCALE
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic scan_valid,
	input wire logic [3:0] scan_cell,
	input wire logic [13:0] scan_code,
	input wire logic osc_fault,
	input wire logic internal_fault,
	input wire logic cmd_valid,
	input wire logic wake_cmd,
	output logic cmd_ack,
	output logic report_valid,
	output logic [13:0] report_data,
	output logic sleep,
	output logic fault_n,
	output logic irq
);
	localparam int FW = cfd_pkg::FS_W;
	localparam int IW = cfd_pkg::IRQ_W;
	localparam int CW = cfd_pkg::CNT_W;

	logic aw_hold_reg;
	logic [7:0] aw_addr_reg;
	logic w_hold_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic [FW-1:0] status_reg;
	logic [13:0] ov_limit_reg;
	logic [13:0] uv_limit_reg;
	logic [2:0] filter_sample_count_reg;
	logic [2:0] filter_prev_reg;
	logic [CELLS-1:0] cell_off_reg;
	logic [CELLS-1:0] ov_fault_reg;
	logic [CELLS-1:0] uv_fault_reg;
	logic [IW-1:0] irq_status_reg;
	logic [IW-1:0] irq_mask_reg;
	logic osc_seen_reg;

	// write path: address and data may arrive in either order
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire aw_have = aw_hold_reg || aw_take;
	wire w_have = w_hold_reg || w_take;
	wire [7:0] wr_addr = aw_hold_reg ? aw_addr_reg : s_axi_awaddr;
	wire [31:0] wr_data = w_hold_reg ? w_data_reg : s_axi_wdata;
	wire [3:0] wr_strb = w_hold_reg ? w_strb_reg : s_axi_wstrb;
	wire wr_fire = aw_have && w_have && !s_axi_bvalid;
	wire [31:0] strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}},
		{8{wr_strb[0]}}};
	// prot bits are not decoded: every access has the same rights
	// a ready drops for a cycle after each beat, so a held beat is never taken twice
	wire aw_ready_next = !aw_have && !s_axi_awready && !s_axi_bvalid;
	wire w_ready_next = !w_have && !s_axi_wready && !s_axi_bvalid;
	wire ar_ready_next = !s_axi_arready && !s_axi_rvalid;

	function automatic logic hit_addr(input logic [7:0] a, input logic [7:0] off);
		hit_addr = a == off;
	endfunction : hit_addr

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction : merge

	wire wr_status = wr_fire && hit_addr(wr_addr, cfd_pkg::OFF_FAULT_STATUS);
	wire wr_ovl = wr_fire && hit_addr(wr_addr, cfd_pkg::OFF_OV_LIMIT);
	wire wr_uvl = wr_fire && hit_addr(wr_addr, cfd_pkg::OFF_UV_LIMIT);
	wire wr_setup = wr_fire && hit_addr(wr_addr, cfd_pkg::OFF_FAULT_SETUP);
	wire wr_cells = wr_fire && hit_addr(wr_addr, cfd_pkg::OFF_CELL_SETUP);
	wire wr_ovf = wr_fire && hit_addr(wr_addr, cfd_pkg::OFF_OV_FAULT);
	wire wr_uvf = wr_fire && hit_addr(wr_addr, cfd_pkg::OFF_UV_FAULT);
	wire wr_istat = wr_fire && hit_addr(wr_addr, cfd_pkg::OFF_IRQ_STATUS);
	wire wr_imask = wr_fire && hit_addr(wr_addr, cfd_pkg::OFF_IRQ_MASK);
	wire wr_known = wr_status || wr_ovl || wr_uvl || wr_setup || wr_cells || wr_ovf
		|| wr_uvf || wr_istat || wr_imask || hit_addr(wr_addr, cfd_pkg::OFF_DEV_STATE);
	wire [31:0] wd_m = merge(32'h0000_0000, wr_data, strb_mask);

	// scan comparison and filtering
	wire cell_ok = scan_cell < 4'(CELLS);
	wire [CELLS-1:0] cell_dec = cell_ok ? CELLS'(1) << scan_cell : '0;
	wire cell_on = |(cell_dec & ~cell_off_reg);
	wire scan_live = scan_valid && cell_ok && cell_on && !sleep;
	wire [13:0] code_clip = (scan_code > FULL_SCALE) ? FULL_SCALE : scan_code;
	wire ov_hit = code_clip > ov_limit_reg;
	wire uv_hit = code_clip < uv_limit_reg;
	wire [CW-1:0] target = CW'(1) << filter_sample_count_reg;
	wire filter_clear = filter_sample_count_reg != filter_prev_reg;
	wire [CELLS-1:0] ov_set;
	wire [CELLS-1:0] uv_set;

	// counts live in the sub-block and clear one cycle after the sample count changes
	cfd_cell_filter #(.CELLS(CELLS), .CNT_W(cfd_pkg::CNT_W)) u_filter (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear_all(filter_clear),
		.res_valid(scan_live),
		.res_cell(scan_cell),
		.res_ov(ov_hit),
		.res_uv(uv_hit),
		.target(target),
		.ov_set(ov_set),
		.uv_set(uv_set)
	);

	// fault status: hardware sets win over host clears
	wire [CELLS-1:0] ov_fault_next = (wr_ovf ? ov_fault_reg & wd_m[CELLS-1:0]
		: ov_fault_reg) | ov_set;
	wire [CELLS-1:0] uv_fault_next = (wr_uvf ? uv_fault_reg & wd_m[CELLS-1:0]
		: uv_fault_reg) | uv_set;
	// only a fresh oscillator fault enters sleep; a standing one does not re-enter after wake
	wire osc_event = osc_fault && !status_reg[cfd_pkg::FS_OSC];
	wire [FW-1:0] fs_set = {internal_fault, |uv_set, |ov_set, osc_fault};
	// data bits must be cleared first, so their summary bits hold on
	wire [FW-1:0] fs_keep = {1'b0, |uv_fault_reg, |ov_fault_reg, 1'b0};
	wire [FW-1:0] fs_wr = status_reg & (wd_m[FW-1:0] | fs_keep);
	wire [FW-1:0] status_next = (wr_status ? fs_wr : status_reg) | fs_set;
	wire new_fault = |(fs_set & ~status_reg);
	wire first_fault = (status_reg == '0) && (fs_set != '0);
	wire [IW-1:0] irq_ev = {osc_event, first_fault, new_fault};
	wire [IW-1:0] irq_next = (wr_istat ? irq_status_reg & ~wd_m[IW-1:0]
		: irq_status_reg) | irq_ev;

	// read path
	wire [7:0] ra = s_axi_araddr;
	wire rd_fire = s_axi_arvalid && s_axi_arready;
	wire rd_status = hit_addr(ra, cfd_pkg::OFF_FAULT_STATUS);
	wire rd_ovl = hit_addr(ra, cfd_pkg::OFF_OV_LIMIT);
	wire rd_uvl = hit_addr(ra, cfd_pkg::OFF_UV_LIMIT);
	wire rd_setup = hit_addr(ra, cfd_pkg::OFF_FAULT_SETUP);
	wire rd_cells = hit_addr(ra, cfd_pkg::OFF_CELL_SETUP);
	wire rd_ovf = hit_addr(ra, cfd_pkg::OFF_OV_FAULT);
	wire rd_uvf = hit_addr(ra, cfd_pkg::OFF_UV_FAULT);
	wire rd_istat = hit_addr(ra, cfd_pkg::OFF_IRQ_STATUS);
	wire rd_imask = hit_addr(ra, cfd_pkg::OFF_IRQ_MASK);
	wire rd_state = hit_addr(ra, cfd_pkg::OFF_DEV_STATE);
	wire [31:0] rd_word =
		rd_status ? 32'(status_reg) :
		rd_ovl ? 32'(ov_limit_reg) :
		rd_uvl ? 32'(uv_limit_reg) :
		rd_setup ? 32'(filter_sample_count_reg) :
		rd_cells ? 32'(cell_off_reg) :
		rd_ovf ? 32'(ov_fault_reg) :
		rd_uvf ? 32'(uv_fault_reg) :
		rd_istat ? 32'(irq_status_reg) :
		rd_imask ? 32'(irq_mask_reg) :
		rd_state ? 32'(sleep) : 32'h0000_0000;
	wire rd_known = hit_addr(ra, cfd_pkg::OFF_FAULT_STATUS) || (ra <= cfd_pkg::OFF_DEV_STATE
		&& ra[1:0] == 2'b00);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_hold_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= cfd_pkg::RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_hold_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (w_take) begin
				w_hold_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? cfd_pkg::RESP_OKAY : cfd_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			s_axi_awready <= aw_ready_next;
			s_axi_wready <= w_ready_next;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= cfd_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= ar_ready_next;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_known ? cfd_pkg::RESP_OKAY : cfd_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// limits reset to zero, so every nonzero scan code is an overvoltage hit until the host sets them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ov_limit_reg <= cfd_pkg::RST_LIMIT;
			uv_limit_reg <= cfd_pkg::RST_LIMIT;
			filter_sample_count_reg <= cfd_pkg::RST_FILTER_SEL;
			filter_prev_reg <= cfd_pkg::RST_FILTER_SEL;
			cell_off_reg <= '0;
			irq_mask_reg <= '0;
		end else begin
			filter_prev_reg <= filter_sample_count_reg;
			if (wr_ovl)
				ov_limit_reg <= 14'(merge(32'(ov_limit_reg), wr_data, strb_mask));
			if (wr_uvl)
				uv_limit_reg <= 14'(merge(32'(uv_limit_reg), wr_data, strb_mask));
			if (wr_setup && wr_strb[0])
				filter_sample_count_reg <= wr_data[2:0];
			if (wr_cells)
				cell_off_reg <= CELLS'(merge(32'(cell_off_reg), wr_data, strb_mask));
			if (wr_imask)
				irq_mask_reg <= IW'(merge(32'(irq_mask_reg), wr_data, strb_mask));
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_reg <= '0;
			ov_fault_reg <= '0;
			uv_fault_reg <= '0;
			irq_status_reg <= '0;
			osc_seen_reg <= 1'b0;
			sleep <= 1'b0;
			cmd_ack <= 1'b0;
			report_valid <= 1'b0;
			report_data <= 14'h0000;
			fault_n <= 1'b1;
			irq <= 1'b0;
		end else begin
			status_reg <= status_next;
			ov_fault_reg <= ov_fault_next;
			uv_fault_reg <= uv_fault_next;
			irq_status_reg <= irq_next;
			osc_seen_reg <= osc_event;
			// flag lands this cycle, sleep the next
			if (osc_seen_reg)
				sleep <= 1'b1;
			else if (wake_cmd)
				sleep <= 1'b0;
			cmd_ack <= cmd_valid && !sleep;
			report_valid <= first_fault;
			if (first_fault)
				report_data <= 14'(status_next);
			fault_n <= !(|status_next);
			irq <= |(irq_next & irq_mask_reg);
		end
	end
endmodule : cfd_top

// ==== core/cfd_pkg.sv ====
// Purpose: shared constants for the cell fault detector
// Assumes: 32-bit AXI4-Lite register map, one word per register
// Notes: the interrupt register has its own bit layout, not that of the fault status register
package cfd_pkg;
	localparam int CELLS = 12;
	localparam int CODE_W = 14;
	localparam int CNT_W = 8;
	localparam logic [7:0] OFF_FAULT_STATUS = 8'h00;
	localparam logic [7:0] OFF_OV_LIMIT = 8'h04;
	localparam logic [7:0] OFF_UV_LIMIT = 8'h08;
	localparam logic [7:0] OFF_FAULT_SETUP = 8'h0C;
	localparam logic [7:0] OFF_CELL_SETUP = 8'h10;
	localparam logic [7:0] OFF_OV_FAULT = 8'h14;
	localparam logic [7:0] OFF_UV_FAULT = 8'h18;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h1C;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
	localparam logic [7:0] OFF_DEV_STATE = 8'h24;
	localparam int FS_OSC = 0;
	localparam int FS_OV = 1;
	localparam int FS_UV = 2;
	localparam int FS_INT = 3;
	localparam int FS_W = 4;
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_REPORT = 1;
	localparam int IRQ_SLEEP = 2;
	localparam int IRQ_W = 3;
	localparam logic [2:0] RST_FILTER_SEL = 3'h3;
	localparam logic [13:0] RST_LIMIT = 14'h0000;
	localparam logic [13:0] FULL_SCALE = 14'h1FFF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cfd_pkg

// ==== core/cfd_cell_filter.sv ====
// Purpose: per-cell consecutive-hit filters for over and undervoltage
// Assumes: one scan result per valid cycle, cell index below CELLS
// Notes: a hit counter saturates at the target so a fault is raised once per run
`timescale 1ns/1ps
module cfd_cell_filter #(
	parameter int CELLS = 12,
	parameter int CNT_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clear_all,
	input wire logic res_valid,
	input wire logic [3:0] res_cell,
	input wire logic res_ov,
	input wire logic res_uv,
	input wire logic [CNT_W-1:0] target,
	output logic [CELLS-1:0] ov_set,
	output logic [CELLS-1:0] uv_set
);
	logic [CNT_W-1:0] ov_cnt_reg [CELLS];
	logic [CNT_W-1:0] uv_cnt_reg [CELLS];

	function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] c,
			input logic [CNT_W-1:0] t);
		bump = (c >= t) ? t : c + 1'b1;
	endfunction : bump

	always_ff @(posedge aclk) begin
		for (int i = 0; i < CELLS; i++) begin
			if (!aresetn || clear_all) begin
				ov_cnt_reg[i] <= '0;
				uv_cnt_reg[i] <= '0;
				ov_set[i] <= 1'b0;
				uv_set[i] <= 1'b0;
			end else if (res_valid && res_cell == 4'(i)) begin
				ov_cnt_reg[i] <= res_ov ? bump(ov_cnt_reg[i], target) : '0;
				uv_cnt_reg[i] <= res_uv ? bump(uv_cnt_reg[i], target) : '0;
				ov_set[i] <= res_ov && bump(ov_cnt_reg[i], target) == target
					&& ov_cnt_reg[i] != target;
				uv_set[i] <= res_uv && bump(uv_cnt_reg[i], target) == target
					&& uv_cnt_reg[i] != target;
			end else begin
				ov_set[i] <= 1'b0;
				uv_set[i] <= 1'b0;
			end
		end
	end
endmodule : cfd_cell_filter

// ==== bench/cfd_sva.sv ====
// Purpose: port-level checks for the cell fault detector
// Assumes: bound to cfd_top, status seen only through fault_n and the report_data snapshot
// Notes: sleep and report timing follow the registered outputs
`timescale 1ns/1ps
module cfd_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic osc_fault,
	input wire logic internal_fault,
	input wire logic cmd_valid,
	input wire logic wake_cmd,
	input wire logic cmd_ack,
	input wire logic report_valid,
	input wire logic [13:0] report_data,
	input wire logic sleep,
	input wire logic fault_n
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_osc_entry;
		!fault_n ##1 sleep;
	endsequence
	sequence s_cmd_awake;
		cmd_valid && !sleep && fault_n;
	endsequence
	a_osc_order: assert property (osc_fault |=> s_osc_entry)
		else $error("oscillator fault not flagged before sleep");
	a_int_flag: assert property (internal_fault |=> !fault_n)
		else $error("internal fault not flagged");
	a_sleep_mute: assert property (cmd_valid && sleep |=> !cmd_ack)
		else $error("command answered while asleep");
	a_cmd_answer: assert property (s_cmd_awake |=> cmd_ack)
		else $error("command not answered while awake");
	a_fault_hold: assert property (!fault_n && !(s_axi_awvalid && s_axi_awready)
		&& !(s_axi_wvalid && s_axi_wready) |=> !fault_n) else $error("fault output released");
	a_report_first: assert property (report_valid |-> $past(fault_n) && !fault_n
		&& report_data != 14'h0000) else $error("report not on first fault");
	a_wake_leave: assert property (wake_cmd && sleep && !osc_fault && !$past(osc_fault)
		|=> !sleep) else $error("wake command did not leave sleep");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
endmodule : cfd_sva

bind cfd_top cfd_sva chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.osc_fault(osc_fault), .internal_fault(internal_fault), .cmd_valid(cmd_valid),
	.wake_cmd(wake_cmd), .cmd_ack(cmd_ack), .report_valid(report_valid),
	.report_data(report_data), .sleep(sleep), .fault_n(fault_n));

// ==== bench/cfd_host.sv ====
// Purpose: host microcontroller model, an AXI4-Lite master
// Assumes: bready and rready held high by the bench
// Notes: waits are open here, the bench watchdog ends a hang
`timescale 1ns/1ps
module cfd_host (
	input wire logic aclk,
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic [1:0] bresp,
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp
);
	initial begin
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0000_0000;
		wvalid = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		// each channel released at its own handshake
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		while (!bvalid) @(posedge aclk);
		r = bresp;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
	endtask : rd
endmodule : cfd_host

// ==== bench/cfd_top_test.sv ====
// Purpose: self-checking bench for the cell fault detector
// Assumes: host model drives the register bus, bench drives scans
// Notes: prot, strobe and response readies are tied
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH %s expected %h seen %h", n, e, g); end end
module cfd_top_test;
	logic aclk, aresetn, scan_valid, osc_fault, internal_fault, cmd_valid, wake_cmd;
	logic [3:0] scan_cell;
	logic [13:0] scan_code, report_data, rep_data;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
	logic [1:0] bresp, rresp, r;
	logic cmd_ack, report_valid, sleep, fault_n, irq;
	int num_errors, checks, reports;
	localparam logic [13:0] HI = 14'h1800;
	localparam logic [13:0] LO = 14'h0050;
	cfd_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
		.scan_valid(scan_valid), .scan_cell(scan_cell), .scan_code(scan_code),
		.osc_fault(osc_fault), .internal_fault(internal_fault), .cmd_valid(cmd_valid),
		.wake_cmd(wake_cmd), .cmd_ack(cmd_ack), .report_valid(report_valid),
		.report_data(report_data), .sleep(sleep), .fault_n(fault_n), .irq(irq));
	cfd_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bresp(bresp),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
		.rdata(rdata), .rresp(rresp));
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	always @(posedge aclk) if (report_valid === 1'b1) begin
		reports++;
		rep_data = report_data;
	end
	task automatic summarize;
		if (num_errors == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [1:0] wr_resp;
		host.wr(a, v, wr_resp);
		`CHK("bresp", cfd_pkg::RESP_OKAY, wr_resp)
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
		logic [31:0] rd_data;
		logic [1:0] rd_resp;
		host.rd(a, rd_data, rd_resp);
		`CHK(n, e, rd_data)
		`CHK("rresp", cfd_pkg::RESP_OKAY, rd_resp)
	endtask : rchk
	task automatic scan(input logic [3:0] c, input logic [13:0] v, input int n);
		repeat (n) begin
			scan_cell <= c;
			scan_code <= v;
			scan_valid <= 1'b1;
			@(posedge aclk);
		end
		scan_valid <= 1'b0;
		@(posedge aclk);
	endtask : scan
	task automatic cmd(input logic e, input string n);
		cmd_valid <= 1'b1;
		@(posedge aclk);
		cmd_valid <= 1'b0;
		@(posedge aclk);
		`CHK(n, e, cmd_ack)
	endtask : cmd
	initial begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		summarize();
	end
	initial begin
		{aresetn, scan_valid, osc_fault, internal_fault, cmd_valid, wake_cmd} = 6'h00;
		scan_cell = 4'h0;
		scan_code = 14'h0000;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rchk(cfd_pkg::OFF_FAULT_STATUS, 32'h0000_0000, "status rst");
		rchk(cfd_pkg::OFF_FAULT_SETUP, 32'(cfd_pkg::RST_FILTER_SEL), "sel rst");
		rchk(cfd_pkg::OFF_OV_LIMIT, 32'(cfd_pkg::RST_LIMIT), "ov limit rst");
		rchk(cfd_pkg::OFF_CELL_SETUP, 32'h0000_0000, "cells rst");
		host.rd(8'h30, d, r);
		`CHK("unmapped rresp", cfd_pkg::RESP_SLVERR, r)
		wr(cfd_pkg::OFF_OV_LIMIT, 32'(cfd_pkg::FULL_SCALE));
		rchk(cfd_pkg::OFF_OV_LIMIT, 32'(cfd_pkg::FULL_SCALE), "ov limit");
		wr(cfd_pkg::OFF_UV_LIMIT, 32'(cfd_pkg::FULL_SCALE));
		rchk(cfd_pkg::OFF_UV_LIMIT, 32'(cfd_pkg::FULL_SCALE), "uv limit");
		wr(cfd_pkg::OFF_OV_LIMIT, 32'h0000_1000);
		wr(cfd_pkg::OFF_UV_LIMIT, 32'h0000_0100);
		wr(cfd_pkg::OFF_CELL_SETUP, 32'h0000_0020);
		scan(4'h5, HI, 8);
		scan(4'h3, HI, 7);
		wr(cfd_pkg::OFF_FAULT_SETUP, 32'h0000_0002);
		wr(cfd_pkg::OFF_FAULT_SETUP, 32'h0000_0003);
		scan(4'h3, HI, 1);
		scan(4'h2, HI, 7);
		scan(4'h2, 14'h1000, 1);
		scan(4'h2, HI, 7);
		rchk(cfd_pkg::OFF_OV_FAULT, 32'h0000_0000, "ov early");
		scan(4'h2, HI, 1);
		// fault_n and the report land one edge after the filter hit, seen one edge later
		repeat (2) @(posedge aclk);
		`CHK("fault_n", 1'b0, fault_n)
		`CHK("reports", 1, reports)
		`CHK("report data", 14'(1 << cfd_pkg::FS_OV), rep_data)
		rchk(cfd_pkg::OFF_FAULT_STATUS, 32'(1) << cfd_pkg::FS_OV, "status ov");
		rchk(cfd_pkg::OFF_OV_FAULT, 32'h0000_0004, "ov cell");
		`CHK("irq masked", 1'b0, irq)
		wr(cfd_pkg::OFF_IRQ_MASK, 32'(1) << cfd_pkg::IRQ_FAULT);
		// irq uses the new mask from the edge after the write
		@(posedge aclk);
		`CHK("irq", 1'b1, irq)
		wr(cfd_pkg::OFF_IRQ_STATUS, 32'h0000_0007);
		`CHK("irq cleared", 1'b0, irq)
		wr(cfd_pkg::OFF_OV_FAULT, 32'h0000_0000);
		wr(cfd_pkg::OFF_FAULT_STATUS, 32'h0000_0000);
		`CHK("fault_n clr", 1'b1, fault_n)
		wr(cfd_pkg::OFF_FAULT_SETUP, 32'h0000_0000);
		scan(4'h5, LO, 1);
		scan(4'h0, LO, 1);
		rchk(cfd_pkg::OFF_UV_FAULT, 32'h0000_0001, "uv cell");
		`CHK("report uv", 14'(1 << cfd_pkg::FS_UV), rep_data)
		`CHK("irq uv", 1'b1, irq)
		wr(cfd_pkg::OFF_UV_FAULT, 32'h0000_0000);
		wr(cfd_pkg::OFF_FAULT_STATUS, 32'h0000_0000);
		internal_fault <= 1'b1;
		@(posedge aclk);
		internal_fault <= 1'b0;
		rchk(cfd_pkg::OFF_FAULT_STATUS, 32'(1) << cfd_pkg::FS_INT, "status int");
		wr(cfd_pkg::OFF_FAULT_STATUS, 32'h0000_0000);
		cmd(1'b1, "ack awake");
		osc_fault <= 1'b1;
		@(posedge aclk);
		osc_fault <= 1'b0;
		rchk(cfd_pkg::OFF_FAULT_STATUS, 32'(1) << cfd_pkg::FS_OSC, "status osc");
		`CHK("sleep", 1'b1, sleep)
		rchk(cfd_pkg::OFF_DEV_STATE, 32'h0000_0001, "sleep reg");
		cmd(1'b0, "ack asleep");
		wake_cmd <= 1'b1;
		@(posedge aclk);
		wake_cmd <= 1'b0;
		cmd(1'b1, "ack woken");
		summarize();
	end
endmodule : cfd_top_test
